// ===== imis_cfg.svh
`ifndef IMIS_CFG_SVH
`define IMIS_CFG_SVH
// Register word indices; byte address is four times the index
`define IMIS_IDX_CTRL1 4'h1
`define IMIS_IDX_CTRL2 4'h2
`define IMIS_IDX_STAT 4'h3
`define IMIS_CTRL1_RST 8'h00
`define IMIS_CTRL2_RST 8'h00
// Control register one fields
`define IMIS_MODE_MSB 5
`define IMIS_MODE_LSB 2
`define IMIS_FACT_MSB 7
`define IMIS_FACT_LSB 6
// Control register two bits
`define IMIS_SINC_BIT 3
`define IMIS_REAL_BIT 5
`define IMIS_ILV_BIT 6
// Inverse sinc taps, outer to centre
`define IMIS_C1 10'sh002
`define IMIS_C2 10'sh3fc
`define IMIS_C3 10'sh00a
`define IMIS_C4 10'sh3dd
`define IMIS_C5 10'sh191
`define IMIS_RESCALE 9
// Square root of two over two, Q15
`define IMIS_ROOT_HALF 17'sh05a82
`define IMIS_FIFO_DEPTH 32
`endif

// ===== imis_pkg.sv
package imis_pkg;
    typedef enum logic [1:0] {imis_x1, imis_x2, imis_x4, imis_x8} imis_interp_t;
    typedef logic signed [15:0] imis_samp_t;
    typedef logic signed [16:0] imis_wide_t;
endpackage

// ===== imis_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module imis_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp, next_wp, rp, next_rp;
    logic [CW-1:0] next_level;
    logic next_wr_ready, next_rd_valid;
    logic [WIDTH-1:0] next_rd_data;
    logic push, pop;

    // Output register is refilled whenever it is empty or being taken and level shows a stored word
    always_comb begin
        push = wr_valid && wr_ready;
        pop = (level != '0) && (!rd_valid || rd_ready);
        next_wp = push ? wp + 1'b1 : wp;
        next_rp = pop ? rp + 1'b1 : rp;
        next_level = level + CW'(push) - CW'(pop);
        next_wr_ready = (next_level != CW'(DEPTH));
        next_rd_valid = pop ? 1'b1 : (rd_valid && !rd_ready);
        next_rd_data = pop ? mem[rp] : rd_data;
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp <= '0;
            rp <= '0;
            level <= '0;
            wr_ready <= 1'b1;
            rd_valid <= 1'b0;
            rd_data <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            level <= next_level;
            wr_ready <= next_wr_ready;
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
        end
    end
endmodule // imis_fifo
`default_nettype wire

// ===== imis_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "imis_cfg.svh"

module imis_core #(
    parameter int FIFO_DEPTH = `IMIS_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [15:0] in_i,
    input wire logic [15:0] in_q,
    output logic [15:0] dac_i,
    output logic [15:0] dac_q
);
    localparam int LW = $clog2(FIFO_DEPTH+1);

    function automatic logic [3:0] reg_idx(input logic [7:0] a);
        return (a[7:6] == 2'h0) ? a[5:2] : 4'hf;
    endfunction

    // Carrier in eighths of the DAC rate; odd steps only exist at 8x
    function automatic logic [2:0] carrier_of(input imis_pkg::imis_interp_t f,
                                              input logic [3:0] m);
        unique case (f)
            imis_pkg::imis_x8: return m[3:1];
            imis_pkg::imis_x4: return {m[2:1], 1'b0};
            imis_pkg::imis_x2: return {m[1], 2'h0};
            imis_pkg::imis_x1: return 3'h0;
        endcase
    endfunction

    function automatic imis_pkg::imis_wide_t rmul(input imis_pkg::imis_wide_t x);
        logic signed [33:0] p;
        p = x * `IMIS_ROOT_HALF;
        return p[31:15];
    endfunction

    function automatic logic [33:0] rotate(input imis_pkg::imis_wide_t a,
                                           input imis_pkg::imis_wide_t b,
                                           input logic [2:0] ang);
        imis_pkg::imis_wide_t s, d;
        s = rmul(a + b);
        d = rmul(b - a);
        unique case (ang)
            3'h0: return {a, b};
            3'h1: return {s, d};
            3'h2: return {b, -a};
            3'h3: return {d, -s};
            3'h4: return {-a, -b};
            3'h5: return {-s, -d};
            3'h6: return {-b, a};
            3'h7: return {-d, s};
        endcase
    endfunction

    // Wide enough for 503 times full scale of a 17-bit tap
    function automatic logic signed [26:0] fir(input logic [8:0][16:0] t);
        logic signed [17:0] p1, p2, p3, p4;
        logic signed [26:0] acc;
        p1 = $signed(t[0]) + $signed(t[8]);
        p2 = $signed(t[1]) + $signed(t[7]);
        p3 = $signed(t[2]) + $signed(t[6]);
        p4 = $signed(t[3]) + $signed(t[5]);
        acc = p1 * `IMIS_C1 + p2 * `IMIS_C2 + p3 * `IMIS_C3 + p4 * `IMIS_C4;
        acc = acc + $signed(t[4]) * `IMIS_C5;
        return acc;
    endfunction

    function automatic imis_pkg::imis_samp_t sat16(input logic signed [26:0] x);
        if (x > 27'sh0007fff) begin
            return 16'h7fff;
        end
        if (x < -27'sh0008000) begin
            return 16'h8000;
        end
        return x[15:0];
    endfunction

    logic [7:0] ctrl1, next_ctrl1, ctrl2, next_ctrl2;
    logic [31:0] next_dat;
    logic next_ack, wb_req, wb_wr;
    logic [7:0] status;
    imis_pkg::imis_interp_t factor;
    logic [3:0] mode;
    logic [2:0] carrier;
    logic sinc_en, real_mode, ilv, shifted;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

    assign mode = ctrl1[`IMIS_MODE_MSB:`IMIS_MODE_LSB];
    assign factor = imis_pkg::imis_interp_t'(ctrl1[`IMIS_FACT_MSB:`IMIS_FACT_LSB]);
    assign shifted = (factor != imis_pkg::imis_x1) && mode[0];
    assign carrier = carrier_of(factor, mode);
    assign sinc_en = ctrl2[`IMIS_SINC_BIT];
    assign real_mode = ctrl2[`IMIS_REAL_BIT];
    assign ilv = ctrl2[`IMIS_ILV_BIT];

    // One-cycle answer; unmapped words read zero and ignore writes
    always_comb begin
        next_ctrl1 = ctrl1;
        next_ctrl2 = ctrl2;
        next_ack = wb_req;
        next_dat = 32'h0;
        if (wb_req) begin
            case (reg_idx(wb_adr_i))
                `IMIS_IDX_CTRL1: next_dat = {24'h0, ctrl1};
                `IMIS_IDX_CTRL2: next_dat = {24'h0, ctrl2};
                `IMIS_IDX_STAT: next_dat = {24'h0, status};
                default: next_dat = 32'h0;
            endcase
        end
        // Writes land on the ack edge, while the master still holds them
        if (wb_wr && reg_idx(wb_adr_i) == `IMIS_IDX_CTRL1) begin
            next_ctrl1 = wb_dat_i[7:0];
        end
        if (wb_wr && reg_idx(wb_adr_i) == `IMIS_IDX_CTRL2) begin
            next_ctrl2 = wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl1 <= `IMIS_CTRL1_RST;
            ctrl2 <= `IMIS_CTRL2_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ctrl1 <= next_ctrl1;
            ctrl2 <= next_ctrl2;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    logic have_i, next_have_i, accept, push;
    logic [15:0] hold_i, next_hold_i;
    logic [31:0] fifo_wdata, rd_data;
    logic rd_valid, data_en;
    logic [LW-1:0] level;

    always_comb begin
        accept = in_valid && in_ready;
        push = accept && (!ilv || have_i);
        fifo_wdata = ilv ? {hold_i, in_i} : {in_i, in_q};
        next_have_i = ilv && (accept ? !have_i : have_i);
        next_hold_i = (accept && ilv && !have_i) ? in_i : hold_i;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            have_i <= 1'b0;
            hold_i <= 16'h0;
        end else begin
            have_i <= next_have_i;
            hold_i <= next_hold_i;
        end
    end

    // Source stalls on in_ready once the DAC side stops draining
    imis_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .wr_valid(push),
        .wr_ready(in_ready),
        .wr_data(fifo_wdata),
        .rd_valid(rd_valid),
        .rd_ready(data_en),
        .rd_data(rd_data),
        .level(level)
    );

    assign status = {shifted, have_i, 6'(level)};

    logic [2:0] div_cnt, next_div_cnt, phase, next_phase, ang;
    logic [5:0] ang_prod;
    logic [15:0] cur_i, next_cur_i, cur_q, next_cur_q;
    imis_pkg::imis_wide_t ext_i, ext_q, mix_i, mix_q, next_mix_i, next_mix_q;
    logic [26:0] mix_wide_i;
    logic [8:0][16:0] taps_i, taps_q, next_taps_i, next_taps_q;
    logic signed [26:0] fir_i, fir_q;
    logic [15:0] next_dac_i, next_dac_q;

    assign ext_i = {cur_i[15], cur_i};
    assign ext_q = {cur_q[15], cur_q};
    assign mix_wide_i = {{10{mix_i[16]}}, mix_i};
    assign fir_i = fir(taps_i);
    assign fir_q = fir(taps_q);

    // one input word per interpolation period; hold keeps it centred
    always_comb begin
        data_en = (div_cnt == 3'h0);
        unique case (factor)
            imis_pkg::imis_x1: next_div_cnt = 3'h0;
            imis_pkg::imis_x2: next_div_cnt = data_en ? 3'h1 : div_cnt - 3'h1;
            imis_pkg::imis_x4: next_div_cnt = data_en ? 3'h3 : div_cnt - 3'h1;
            imis_pkg::imis_x8: next_div_cnt = data_en ? 3'h7 : div_cnt - 3'h1;
        endcase
        next_cur_i = cur_i;
        next_cur_q = cur_q;
        if (data_en && rd_valid) begin
            {next_cur_i, next_cur_q} = rd_data;
        end
        next_phase = phase + 3'h1;
        ang_prod = carrier * phase;
        ang = ang_prod[2:0];
        {next_mix_i, next_mix_q} = rotate(ext_i, ext_q, ang);
        if (real_mode) begin
            next_mix_i = ext_i;
            next_mix_q = 17'h0;
        end
        next_taps_i = {taps_i[7:0], mix_i};
        next_taps_q = {taps_q[7:0], mix_q};
        // divide by 512 gives about 3.4 dB loss at DC
        if (sinc_en) begin
            next_dac_i = sat16(fir_i >>> `IMIS_RESCALE);
            next_dac_q = sat16(fir_q >>> `IMIS_RESCALE);
        end else begin
            next_dac_i = sat16(mix_wide_i);
            next_dac_q = sat16({{10{mix_q[16]}}, mix_q});
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= 3'h0;
            phase <= 3'h0;
            cur_i <= 16'h0;
            cur_q <= 16'h0;
            mix_i <= 17'h0;
            mix_q <= 17'h0;
            taps_i <= '0;
            taps_q <= '0;
            dac_i <= 16'h0;
            dac_q <= 16'h0;
        end else begin
            div_cnt <= next_div_cnt;
            phase <= next_phase;
            cur_i <= next_cur_i;
            cur_q <= next_cur_q;
            mix_i <= next_mix_i;
            mix_q <= next_mix_q;
            taps_i <= next_taps_i;
            taps_q <= next_taps_q;
            dac_i <= next_dac_i;
            dac_q <= next_dac_q;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    mode_field_a: assert property (
        wb_wr && reg_idx(wb_adr_i) == `IMIS_IDX_CTRL1
        |=> !wb_ack_o && mode == $past(wb_dat_i[5:2]))
        else $error("filter mode field not taken from write");
    three_eighth_a: assert property (
        (carrier == 3'h3 || carrier == 3'h5) |-> factor == imis_pkg::imis_x8)
        else $error("three eighths carrier outside 8x");
    half_rate_a: assert property (
        !real_mode && carrier == 3'h4 && phase[0]
        |=> mix_i == -$past(ext_i) && mix_q == -$past(ext_q))
        else $error("half rate sample not negated");
    quarter_pos_a: assert property (
        !real_mode && carrier == 3'h2 && phase == 3'h1
        |=> mix_i == $past(ext_q) && mix_q == -$past(ext_i))
        else $error("positive quarter rate step wrong");
    quarter_neg_a: assert property (
        !real_mode && carrier == 3'h6 && phase == 3'h1
        |=> mix_i == -$past(ext_q) && mix_q == $past(ext_i))
        else $error("negative quarter rate step wrong");
    eighth_rate_a: assert property (
        !real_mode && carrier == 3'h1 && phase == 3'h1
        |=> mix_i == rmul($past(ext_i) + $past(ext_q))
            && mix_q == rmul($past(ext_q) - $past(ext_i)))
        else $error("eighth rate root-half step wrong");
    sinc_enable_a: assert property (
        $rose(sinc_en) |-> $past(wb_wr && reg_idx(wb_adr_i) == `IMIS_IDX_CTRL2
                                 && wb_dat_i[3]))
        else $error("inverse sinc enabled without a write");
    sinc_taps_a: assert property (
        sinc_en |=> dac_i == sat16($past(fir_i) >>> `IMIS_RESCALE))
        else $error("inverse sinc output mismatch");
    sinc_bypass_a: assert property (
        !sinc_en |=> dac_i == sat16($past(mix_wide_i)))
        else $error("bypass output mismatch");
    real_mode_a: assert property (
        real_mode |=> mix_q == 17'h0 && mix_i == $past(ext_i))
        else $error("real mode left Q or modulation on");
    split_a: assert property (
        accept && ilv && !have_i |=> have_i && hold_i == $past(in_i) && !$past(push))
        else $error("interleaved I sample not held");

    eighth_sinc_c: cover property (sinc_en && carrier == 3'h1 && rd_valid);
    interleave_c: cover property (ilv && push);
    fifo_full_c: cover property (!in_ready);
endmodule // imis_core
`default_nettype wire

// ===== imis_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module imis_src_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_ready,
    input wire logic [6:0] stall_pct,
    output logic in_valid,
    output logic [15:0] in_i,
    output logic [15:0] in_q
);
    // Queued beats, I in the upper half; the bench pushes I then Q for interleave
    logic [31:0] words[$];
    int seed = 25;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            in_valid <= 1'b0;
            in_i <= 16'h0000;
            in_q <= 16'h0000;
        end else if (!(in_valid && !in_ready)) begin
            if (in_valid) begin
                words.delete(0);
            end
            if (words.size() > 0 && ($unsigned($random(seed)) % 100) >= stall_pct) begin
                in_valid <= 1'b1;
                in_i <= words[0][31:16];
                in_q <= words[0][15:0];
            end else begin
                // Idle lines toggle so a stale value never looks valid
                in_valid <= 1'b0;
                in_i <= ~in_i;
                in_q <= ~in_q;
            end
        end
    end
endmodule // imis_src_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0, wb_dat_o;
    logic wb_ack_o, in_valid, in_ready;
    logic [15:0] in_i, in_q, dac_i, dac_q;
    logic [6:0] stall_pct = 7'h00;
    int errors = 0, check_count = 0, seed = 25;
    always #4 clk = ~clk;
    imis_core DUT (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .in_valid(in_valid), .in_ready(in_ready),
        .in_i(in_i), .in_q(in_q), .dac_i(dac_i), .dac_q(dac_q));
    imis_src_model SRC (.clk(clk), .nrst(nrst), .in_ready(in_ready), .stall_pct(stall_pct),
        .in_valid(in_valid), .in_i(in_i), .in_q(in_q));
    task automatic tally_and_finish();
        if (errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic signed [31:0] seen, input logic signed [31:0] exp,
        input int tol);
        check_count++;
        if ((^seen) === 1'bx || seen - exp > tol || exp - seen > tol) begin
            errors++;
            $display("ERROR %0t: saw %0d expected %0d", $time, seen, exp);
        end
    endtask
    function automatic int rot(input int i, input int q, input int a, input bit qs);
        real c, s;
        c = $cos(a * 3.14159265358979 / 4.0);
        s = $sin(a * 3.14159265358979 / 4.0);
        return qs ? int'(q * c - i * s) : int'(i * c + q * s);
    endfunction
    function automatic int ab(input int x);
        return x < 0 ? -x : x;
    endfunction
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] sel, output logic [31:0] r);
        int n;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= sel;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        r = wb_dat_o;
        if (n >= 50) errors++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, 4'hf, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        wb(1'b0, a, 32'h0, 4'hf, r);
    endtask
    // Waits for source and FIFO to empty, then for the output pipeline
    task automatic settle();
        logic [31:0] r;
        int n;
        n = 0;
        do begin
            rd(8'h0c, r);
            n++;
        end while ((SRC.words.size() != 0 || r[5:0] !== 6'h00) && n < 300);
        if (n >= 300) errors++;
        repeat (24) @(negedge clk);
    endtask
    task automatic rot_case(input logic [7:0] c1, input int car);
        int i, q, k, a, n, e, best;
        logic [31:0] r;
        i = 1000 + $unsigned($random(seed)) % 15000;
        q = -1000 - $unsigned($random(seed)) % 15000;
        if ($random(seed) & 1) i = -i;
        wr(8'h04, {24'h0, c1});
        rd(8'h0c, r);
        check(r[7], (c1[7:6] != 2'b00) && c1[2], 0);
        SRC.words.push_back({i[15:0], q[15:0]});
        settle();
        best = 1 << 30;
        k = 0;
        // Phase alignment only; every later step is predicted
        for (a = 0; a < 8; a++) begin
            e = ab(rot(i, q, a, 0) - $signed(dac_i)) + ab(rot(i, q, a, 1) - $signed(dac_q));
            if (e < best) begin
                best = e;
                k = a;
            end
        end
        for (n = 1; n <= 8; n++) begin
            @(negedge clk);
            a = (k + car * n) % 8;
            check($signed(dac_i), rot(i, q, a, 0), 2);
            check($signed(dac_q), rot(i, q, a, 1), 2);
        end
    endtask
    task automatic impulse(input bit sinc);
        int h[9] = '{2, -4, 10, -35, 401, -35, 10, -4, 2};
        int t, e;
        repeat (12) SRC.words.push_back(32'h0);
        // Flush the held sample so the first non-zero output is the impulse
        settle();
        SRC.words.push_back({16'sd2048, -16'sd2048});
        repeat (12) SRC.words.push_back(32'h0);
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while (dac_i === 16'h0000 && t < 100);
        for (t = 0; t < 9; t++) begin
            e = sinc ? h[t] * 4 : (t == 0 ? 2048 : 0);
            check($signed(dac_i), e, 0);
            check($signed(dac_q), -e, 0);
            @(negedge clk);
        end
    endtask
    initial begin
        #400000;
        errors++;
        tally_and_finish();
    end
    initial begin
        logic [31:0] r;
        int f, m, i;
        logic [7:0] w;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd(8'h04, r);
        check(r, 0, 0);
        rd(8'h08, r);
        check(r, 0, 0);
        rd(8'h00, r);
        check(r, 0, 0);
        wr(8'h44, 32'hff);
        wb(1'b1, 8'h04, 32'hff, 4'he, r);
        wr(8'h0c, 32'hff);
        rd(8'h04, r);
        check(r, 0, 0);
        rd(8'h0c, r);
        check(r, 0, 0);
        w = 8'($random(seed));
        wr(8'h04, {24'h0, w});
        rd(8'h04, r);
        check(r, {24'h0, w}, 0);
        for (f = 0; f < 4; f++) begin
            for (m = 0; m < (f == 0 ? 1 : 2 << f); m++) begin
                rot_case({f[1:0], m[3:0], 2'b00}, (m >> 1) << (3 - f));
            end
        end
        // bypass, then enabled taps and full-scale gain
        wr(8'h04, 32'h0);
        impulse(1'b0);
        wr(8'h08, 32'h08);
        impulse(1'b1);
        SRC.words.push_back({16'sd32767, 16'sh8000});
        settle();
        repeat (12) @(negedge clk);
        check($signed(dac_i), 22207, 0);
        check($signed(dac_q), -22208, 0);
        wr(8'h08, 32'h40);
        SRC.words.push_back({16'sd300, 16'h1234});
        SRC.words.push_back({-16'sd500, 16'h4321});
        settle();
        check($signed(dac_i), 300, 0);
        check($signed(dac_q), -500, 0);
        SRC.words.push_back({16'sd77, 16'h0});
        settle();
        rd(8'h0c, r);
        check(r[6], 1, 0);
        wr(8'h08, 32'h0);
        rd(8'h0c, r);
        check(r[6], 0, 0);
        wr(8'h04, 32'hd0);
        wr(8'h08, 32'h20);
        i = $random(seed) % 20000;
        SRC.words.push_back({i[15:0], 16'sd1111});
        settle();
        repeat (8) begin
            @(negedge clk);
            check($signed(dac_i), i, 0);
            check($signed(dac_q), 0, 0);
        end
        // Fill until refused, then drain with a stalling source
        wr(8'h08, 32'h0);
        repeat (48) SRC.words.push_back($random(seed));
        i = 0;
        while (in_ready !== 1'b0 && i < 300) begin
            @(negedge clk);
            i++;
        end
        check(in_ready, 0, 0);
        stall_pct = 7'd60;
        settle();
        check(in_ready, 1, 0);
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
